// >>> inc/timer_pwm_pkg.sv
// constants, register map and types for the timer/pwm counter
package timer_pwm_pkg;

    // register byte addresses, one aligned word each, data in bits 7:0
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_COUNTER_HIGH = 8'h04;
    localparam logic [7:0] ADDR_COUNTER_LOW = 8'h08;
    localparam logic [7:0] ADDR_MODULO_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_MODULO_LOW = 8'h10;
    localparam logic [7:0] ADDR_CHANNEL_CONTROL = 8'h14;
    localparam logic [7:0] ADDR_CHANNEL_HIGH = 8'h18;
    localparam logic [7:0] ADDR_CHANNEL_LOW = 8'h1C;

    // status/control fields
    localparam int BIT_OVERFLOW_FLAG = 7;
    localparam int BIT_CENTER_ALIGNED_SELECT = 5;
    localparam int BIT_CLOCK_SELECT_HI = 4;
    localparam int BIT_CLOCK_SELECT_LO = 3;
    // channel control fields
    localparam int BIT_EDGE_LEVEL_SELECT_A = 2;

    // clock select codes
    localparam logic [1:0] CLOCK_STOPPED = 2'h0;
    localparam logic [1:0] CLOCK_BUS = 2'h1;

    // counter values
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [15:0] FREE_RUN_TOP = 16'hFFFF;
    localparam logic [15:0] MODULO_RESET = 16'h0000;
    localparam logic [15:0] CHANNEL_RESET = 16'h0000;
    localparam int BIT_SIGN = 15;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } count_dir_t;

endpackage : timer_pwm_pkg

// >>> rtl/level_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
module level_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_reg;
    logic [WIDTH-1:0] sync_reg;

    // the first stage feeds only the second stage
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stage_reg <= '0;
            sync_reg <= '0;
        end else begin
            stage_reg <= async_in;
            sync_reg <= stage_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule : level_sync

// >>> rtl/timer_pwm_counter.sv
// 16-bit timer counter with buffered modulo and channel, edge/center pwm
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
module timer_pwm_counter (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pins
    input wire logic debug_mode,
    input wire logic ext_tick,
    output logic pwm_out
);
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction : hit

    logic [1:0] pins_sync;
    logic dbg;
    logic tick_lvl;

    level_sync #(.WIDTH(2)) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .async_in({debug_mode, ext_tick}),
        .sync_out(pins_sync)
    );
    assign dbg = pins_sync[1];
    assign tick_lvl = pins_sync[0];

    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic tick_prev_reg, tick_prev_next;
    logic [15:0] cnt_reg, cnt_next;
    timer_pwm_pkg::count_dir_t dir_reg, dir_next;
    logic tof_reg, tof_next;
    logic center_reg, center_next;
    logic [1:0] clk_sel_reg, clk_sel_next;
    logic elsa_reg, elsa_next;
    logic coh_valid_reg, coh_valid_next;
    logic [15:0] coh_val_reg, coh_val_next;
    logic [15:0] mod_reg, mod_next;
    logic [15:0] mod_buf_reg, mod_buf_next;
    logic mod_hi_seen_reg, mod_hi_seen_next;
    logic mod_lo_seen_reg, mod_lo_seen_next;
    logic [15:0] cv_reg, cv_next;
    logic [15:0] cv_buf_reg, cv_buf_next;
    logic cv_hi_seen_reg, cv_hi_seen_next;
    logic cv_lo_seen_reg, cv_lo_seen_next;
    logic pwm_reg, pwm_next;

    // decoded strobes, shared with the checks below
    logic rd_go, wr_go, tick, stepping_top, mod_partial;
    logic [15:0] top;
    logic [15:0] count_step;
    logic active;

    always_comb begin
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        rd_go = ack_next && !wb_we_i;
        // a write lands at the edge where the master samples ack
        wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
        tick_prev_next = tick_lvl;
        // counter stands still while the select is zero
        tick = 1'b0;
        if (clk_sel_reg == timer_pwm_pkg::CLOCK_BUS) begin
            tick = 1'b1;
        end else if (clk_sel_reg != timer_pwm_pkg::CLOCK_STOPPED) begin
            tick = tick_lvl && !tick_prev_reg;
        end
        // modulo of zero lets the counter run the full range
        top = (mod_reg == timer_pwm_pkg::MODULO_RESET) ?
            timer_pwm_pkg::FREE_RUN_TOP : mod_reg;
        mod_partial = mod_hi_seen_reg ^ mod_lo_seen_reg;

        dat_next = timer_pwm_pkg::WORD_ZERO;
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        tof_next = tof_reg;
        center_next = center_reg;
        clk_sel_next = clk_sel_reg;
        elsa_next = elsa_reg;
        coh_valid_next = coh_valid_reg;
        coh_val_next = coh_val_reg;
        mod_next = mod_reg;
        mod_buf_next = mod_buf_reg;
        mod_hi_seen_next = mod_hi_seen_reg;
        mod_lo_seen_next = mod_lo_seen_reg;
        cv_next = cv_reg;
        cv_buf_next = cv_buf_reg;
        cv_hi_seen_next = cv_hi_seen_reg;
        cv_lo_seen_next = cv_lo_seen_reg;
        count_step = cnt_reg;
        stepping_top = 1'b0;

        // counting; debug freezes the counter
        if (tick && !dbg) begin
            if (!center_reg) begin
                if (cnt_reg == top) begin
                    count_step = timer_pwm_pkg::COUNT_ZERO;
                    if (!mod_partial) begin
                        tof_next = 1'b1;
                    end
                end else begin
                    count_step = 16'(cnt_reg + timer_pwm_pkg::COUNT_ONE);
                end
                dir_next = timer_pwm_pkg::DIR_UP;
            end else begin
                case (dir_reg)
                    timer_pwm_pkg::DIR_UP: begin
                        if (cnt_reg == top) begin
                            dir_next = timer_pwm_pkg::DIR_DOWN;
                            count_step = 16'(cnt_reg - timer_pwm_pkg::COUNT_ONE);
                        end else begin
                            count_step = 16'(cnt_reg + timer_pwm_pkg::COUNT_ONE);
                        end
                    end
                    timer_pwm_pkg::DIR_DOWN: begin
                        if (cnt_reg == timer_pwm_pkg::COUNT_ZERO) begin
                            dir_next = timer_pwm_pkg::DIR_UP;
                            count_step = timer_pwm_pkg::COUNT_ONE;
                            if (!mod_partial) begin
                                tof_next = 1'b1;
                            end
                        end else begin
                            count_step = 16'(cnt_reg - timer_pwm_pkg::COUNT_ONE);
                        end
                    end
                    default: begin
                        dir_next = timer_pwm_pkg::DIR_UP;
                    end
                endcase
            end
            stepping_top = (count_step == top) && (cnt_reg != top);
            cnt_next = count_step;
        end

        // buffered loads when the counter steps onto its top
        if (clk_sel_reg != timer_pwm_pkg::CLOCK_STOPPED && stepping_top) begin
            if (mod_hi_seen_reg && mod_lo_seen_reg) begin
                mod_next = mod_buf_reg;
                mod_hi_seen_next = 1'b0;
                mod_lo_seen_next = 1'b0;
            end
            if (cv_hi_seen_reg && cv_lo_seen_reg) begin
                cv_next = cv_buf_reg;
                cv_hi_seen_next = 1'b0;
                cv_lo_seen_next = 1'b0;
            end
        end

        // reads: counter halves pair through the coherency latch
        if (rd_go) begin
            case (1'b1)
                hit(wb_adr_i, timer_pwm_pkg::ADDR_STATUS_CONTROL): begin
                    dat_next[timer_pwm_pkg::BIT_OVERFLOW_FLAG] = tof_reg;
                    dat_next[timer_pwm_pkg::BIT_CENTER_ALIGNED_SELECT] = center_reg;
                    dat_next[timer_pwm_pkg::BIT_CLOCK_SELECT_HI] = clk_sel_reg[1];
                    dat_next[timer_pwm_pkg::BIT_CLOCK_SELECT_LO] = clk_sel_reg[0];
                end
                hit(wb_adr_i, timer_pwm_pkg::ADDR_COUNTER_HIGH): begin
                    dat_next[7:0] = coh_valid_reg ? coh_val_reg[15:8] : cnt_reg[15:8];
                end
                hit(wb_adr_i, timer_pwm_pkg::ADDR_COUNTER_LOW): begin
                    dat_next[7:0] = coh_valid_reg ? coh_val_reg[7:0] : cnt_reg[7:0];
                end
                hit(wb_adr_i, timer_pwm_pkg::ADDR_MODULO_HIGH): begin
                    dat_next[7:0] = mod_reg[15:8];
                end
                hit(wb_adr_i, timer_pwm_pkg::ADDR_MODULO_LOW): begin
                    dat_next[7:0] = mod_reg[7:0];
                end
                hit(wb_adr_i, timer_pwm_pkg::ADDR_CHANNEL_CONTROL): begin
                    dat_next[timer_pwm_pkg::BIT_EDGE_LEVEL_SELECT_A] = elsa_reg;
                end
                hit(wb_adr_i, timer_pwm_pkg::ADDR_CHANNEL_HIGH): begin
                    dat_next[7:0] = cv_reg[15:8];
                end
                hit(wb_adr_i, timer_pwm_pkg::ADDR_CHANNEL_LOW): begin
                    dat_next[7:0] = cv_reg[7:0];
                end
                default: begin
                    dat_next = timer_pwm_pkg::WORD_ZERO;
                end
            endcase
            // first half read latches the count, second half releases it
            if (!dbg && (hit(wb_adr_i, timer_pwm_pkg::ADDR_COUNTER_HIGH) ||
                         hit(wb_adr_i, timer_pwm_pkg::ADDR_COUNTER_LOW))) begin
                coh_valid_next = !coh_valid_reg;
                coh_val_next = cnt_reg;
            end
        end

        // writes
        if (wr_go) begin
            if (hit(wb_adr_i, timer_pwm_pkg::ADDR_STATUS_CONTROL)) begin
                center_next = wb_dat_i[timer_pwm_pkg::BIT_CENTER_ALIGNED_SELECT];
                clk_sel_next = {wb_dat_i[timer_pwm_pkg::BIT_CLOCK_SELECT_HI],
                                wb_dat_i[timer_pwm_pkg::BIT_CLOCK_SELECT_LO]};
                // writing zero clears the flag unless it was clear and a wrap sets it now
                if (!wb_dat_i[timer_pwm_pkg::BIT_OVERFLOW_FLAG] && tof_next == tof_reg) begin
                    tof_next = 1'b0;
                end
                mod_hi_seen_next = 1'b0;
                mod_lo_seen_next = 1'b0;
                if (dbg) begin
                    coh_valid_next = 1'b0;
                end
            end
            if (hit(wb_adr_i, timer_pwm_pkg::ADDR_COUNTER_HIGH) ||
                hit(wb_adr_i, timer_pwm_pkg::ADDR_COUNTER_LOW)) begin
                cnt_next = timer_pwm_pkg::COUNT_ZERO;
                dir_next = timer_pwm_pkg::DIR_UP;
                coh_valid_next = 1'b0;
            end
            if (hit(wb_adr_i, timer_pwm_pkg::ADDR_MODULO_HIGH)) begin
                mod_buf_next[15:8] = wb_dat_i[7:0];
                mod_hi_seen_next = 1'b1;
            end
            if (hit(wb_adr_i, timer_pwm_pkg::ADDR_MODULO_LOW)) begin
                mod_buf_next[7:0] = wb_dat_i[7:0];
                mod_lo_seen_next = 1'b1;
            end
            if (hit(wb_adr_i, timer_pwm_pkg::ADDR_CHANNEL_CONTROL)) begin
                elsa_next = wb_dat_i[timer_pwm_pkg::BIT_EDGE_LEVEL_SELECT_A];
            end
            // channel bytes never touch the live compare value directly
            if (hit(wb_adr_i, timer_pwm_pkg::ADDR_CHANNEL_HIGH)) begin
                cv_buf_next[15:8] = wb_dat_i[7:0];
                cv_hi_seen_next = 1'b1;
            end
            if (hit(wb_adr_i, timer_pwm_pkg::ADDR_CHANNEL_LOW)) begin
                cv_buf_next[7:0] = wb_dat_i[7:0];
                cv_lo_seen_next = 1'b1;
            end
        end

        // stopped clock: second byte loads at once
        if (clk_sel_reg == timer_pwm_pkg::CLOCK_STOPPED) begin
            if (mod_hi_seen_next && mod_lo_seen_next) begin
                mod_next = mod_buf_next;
                mod_hi_seen_next = 1'b0;
                mod_lo_seen_next = 1'b0;
            end
            if (cv_hi_seen_next && cv_lo_seen_next) begin
                cv_next = cv_buf_next;
                cv_hi_seen_next = 1'b0;
                cv_lo_seen_next = 1'b0;
            end
        end

        // pwm: a compare gives the edge waveform, and center adds a sign and zero gate;
        // in center mode the level flips at each up and down match
        if (center_reg) begin
            active = !cv_reg[timer_pwm_pkg::BIT_SIGN] &&
                     (cv_reg != timer_pwm_pkg::CHANNEL_RESET) &&
                     (cnt_reg < cv_reg);
        end else begin
            active = cnt_reg < cv_reg;
        end
        pwm_next = active ^ elsa_reg;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
            dat_reg <= timer_pwm_pkg::WORD_ZERO;
            tick_prev_reg <= 1'b0;
            cnt_reg <= timer_pwm_pkg::COUNT_ZERO;
            dir_reg <= timer_pwm_pkg::DIR_UP;
            tof_reg <= 1'b0;
            center_reg <= 1'b0;
            clk_sel_reg <= timer_pwm_pkg::CLOCK_STOPPED;
            elsa_reg <= 1'b0;
            coh_valid_reg <= 1'b0;
            coh_val_reg <= timer_pwm_pkg::COUNT_ZERO;
            mod_reg <= timer_pwm_pkg::MODULO_RESET;
            mod_buf_reg <= timer_pwm_pkg::MODULO_RESET;
            mod_hi_seen_reg <= 1'b0;
            mod_lo_seen_reg <= 1'b0;
            cv_reg <= timer_pwm_pkg::CHANNEL_RESET;
            cv_buf_reg <= timer_pwm_pkg::CHANNEL_RESET;
            cv_hi_seen_reg <= 1'b0;
            cv_lo_seen_reg <= 1'b0;
            pwm_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            tick_prev_reg <= tick_prev_next;
            cnt_reg <= cnt_next;
            dir_reg <= dir_next;
            tof_reg <= tof_next;
            center_reg <= center_next;
            clk_sel_reg <= clk_sel_next;
            elsa_reg <= elsa_next;
            coh_valid_reg <= coh_valid_next;
            coh_val_reg <= coh_val_next;
            mod_reg <= mod_next;
            mod_buf_reg <= mod_buf_next;
            mod_hi_seen_reg <= mod_hi_seen_next;
            mod_lo_seen_reg <= mod_lo_seen_next;
            cv_reg <= cv_next;
            cv_buf_reg <= cv_buf_next;
            cv_hi_seen_reg <= cv_hi_seen_next;
            cv_lo_seen_reg <= cv_lo_seen_next;
            pwm_reg <= pwm_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign pwm_out = pwm_reg;

    // checks
    logic cnt_wr;
    logic sc_wr;
    assign cnt_wr = wr_go && (hit(wb_adr_i, timer_pwm_pkg::ADDR_COUNTER_HIGH) ||
                              hit(wb_adr_i, timer_pwm_pkg::ADDR_COUNTER_LOW));
    assign sc_wr = wr_go && hit(wb_adr_i, timer_pwm_pkg::ADDR_STATUS_CONTROL);

    sequence s_mod_second_byte;
        wr_go && clk_sel_reg == timer_pwm_pkg::CLOCK_STOPPED &&
        hit(wb_adr_i, timer_pwm_pkg::ADDR_MODULO_LOW) && mod_hi_seen_reg;
    endsequence
    sequence s_up_at_top;
        tick && !dbg && center_reg && dir_reg == timer_pwm_pkg::DIR_UP &&
        cnt_reg == top && !cnt_wr;
    endsequence
    sequence s_down_at_zero;
        tick && !dbg && center_reg && dir_reg == timer_pwm_pkg::DIR_DOWN &&
        cnt_reg == timer_pwm_pkg::COUNT_ZERO && !cnt_wr;
    endsequence

    a_counter_write_clears: assert property (@(posedge mclk) disable iff (!nrst)
        cnt_wr |=> cnt_reg == timer_pwm_pkg::COUNT_ZERO && !coh_valid_reg)
        else $error("counter write did not clear counter");
    a_debug_freeze: assert property (@(posedge mclk) disable iff (!nrst)
        dbg && !cnt_wr && !sc_wr |=> $stable(cnt_reg) && $stable(coh_valid_reg))
        else $error("counter or latch moved in debug");
    a_debug_sc_reset: assert property (@(posedge mclk) disable iff (!nrst)
        dbg && sc_wr |=> !coh_valid_reg)
        else $error("control write in debug kept latch");
    a_edge_wrap_zero: assert property (@(posedge mclk) disable iff (!nrst)
        tick && !dbg && !center_reg && cnt_reg == top && !cnt_wr && !mod_partial
        && !sc_wr |=> cnt_reg == timer_pwm_pkg::COUNT_ZERO && tof_reg)
        else $error("wrap at modulo failed");
    a_tof_inhibit: assert property (@(posedge mclk) disable iff (!nrst)
        !tof_reg && mod_partial && !wr_go |=> !tof_reg)
        else $error("overflow set with half-written modulo");
    a_mod_immediate: assert property (@(posedge mclk) disable iff (!nrst)
        s_mod_second_byte |=> mod_reg == {$past(mod_buf_reg[15:8]), $past(wb_dat_i[7:0])})
        else $error("modulo not loaded at second byte");
    a_mod_deferred: assert property (@(posedge mclk) disable iff (!nrst)
        clk_sel_reg != timer_pwm_pkg::CLOCK_STOPPED && !stepping_top |=> $stable(mod_reg))
        else $error("modulo changed off the step to top");
    a_sc_unlatch: assert property (@(posedge mclk) disable iff (!nrst)
        sc_wr |=> !mod_hi_seen_reg && !mod_lo_seen_reg)
        else $error("control write kept modulo latching");
    a_zero_duty: assert property (@(posedge mclk) disable iff (!nrst)
        cv_reg == timer_pwm_pkg::CHANNEL_RESET ##1 $stable(elsa_reg)
        |-> pwm_reg == elsa_reg)
        else $error("zero channel value gave a pulse");
    a_center_negative: assert property (@(posedge mclk) disable iff (!nrst)
        center_reg && cv_reg[timer_pwm_pkg::BIT_SIGN] ##1 $stable(elsa_reg)
        |-> pwm_reg == elsa_reg)
        else $error("negative value gave a pulse");
    a_center_reverse: assert property (@(posedge mclk) disable iff (!nrst)
        (s_up_at_top |=> dir_reg == timer_pwm_pkg::DIR_DOWN) and
        (s_down_at_zero |=> dir_reg == timer_pwm_pkg::DIR_UP &&
         cnt_reg == timer_pwm_pkg::COUNT_ONE))
        else $error("center count did not reverse");
    a_stopped_holds: assert property (@(posedge mclk) disable iff (!nrst)
        (clk_sel_reg == timer_pwm_pkg::CLOCK_STOPPED && !cnt_wr) [*2] |-> $stable(cnt_reg))
        else $error("counter moved with clock stopped");

endmodule : timer_pwm_counter

// >>> tb/pwm_load.sv
// load model on the pwm pin: counts high cycles since the last clear
`timescale 1ns/10ps
module pwm_load (
    // clock
    input wire logic mclk,
    // pin and control
    input wire logic pwm_in,
    input wire logic clr,
    output int high_cnt
);
    // an unknown level never counts as high
    always @(posedge mclk) begin
        if (clr) high_cnt <= 0;
        else if (pwm_in === 1'b1) high_cnt <= high_cnt + 1;
    end
endmodule : pwm_load

// >>> tb/tb_timer_pwm_counter.sv
// self-checking bench for the timer/pwm counter
`timescale 1ns/10ps
module tb_timer_pwm_counter;
    logic mclk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, dbg = 0, tick = 0, clr = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat_w = 32'h0000_0000;
    logic [31:0] dat_r;
    logic ack, pwm;
    logic [15:0] v, w;
    int high_cnt, bad_count = 0, checks_done = 0;
    always #4 mclk = ~mclk;
    timer_pwm_counter u_timer_pwm_counter (.mclk(mclk), .nrst(nrst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat_w),
        .wb_dat_o(dat_r), .wb_ack_o(ack), .debug_mode(dbg), .ext_tick(tick), .pwm_out(pwm));
    pwm_load u_pwm_load (.mclk(mclk), .pwm_in(pwm), .clr(clr), .high_cnt(high_cnt));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one classic cycle; waits for ack, then idles one cycle
    task automatic wb(input logic wen, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wen;
        adr <= a;
        dat_w <= {24'h00_0000, d};
        @(posedge mclk);
        // no cycle budget here: only the watchdog ends a stuck wait
        while (ack !== 1'b1) begin
            @(posedge mclk);
        end
        q = dat_r[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a, d[15:8]);
        wr(a + 8'h04, d[7:0]);
    endtask : wr16
    // high half first, so the counter latch gives a coherent pair
    task automatic rd16(input logic [7:0] a, output logic [15:0] r);
        wb(1'b0, a, 8'h00, r[15:8]);
        wb(1'b0, a + 8'h04, 8'h00, r[7:0]);
    endtask : rd16
    task automatic flag(input logic exp);
        wb(1'b0, 8'h00, 8'h00, v[7:0]);
        chk({15'h0000, v[7]}, {15'h0000, exp});
    endtask : flag
    // window of 100 cycles: a whole number of edge periods (10) and of 0/100% cases
    task automatic duty(input logic [15:0] exp);
        repeat (30) @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (100) @(posedge mclk);
        #1 chk(high_cnt[15:0], exp);
    endtask : duty
    task automatic t_reset;
        rd16(8'h04, v);
        chk(v, 16'h0000);
        rd16(8'h0C, v);
        chk(v, 16'h0000);
        wb(1'b0, 8'h20, 8'h00, v[7:0]);
        chk({8'h00, v[7:0]}, 16'h0000);
    endtask : t_reset
    task automatic t_modulo;
        wr(8'h10, 8'h09);
        rd16(8'h0C, v);
        chk(v, 16'h0000);
        wr(8'h0C, 8'h00);
        rd16(8'h0C, v);
        chk(v, 16'h0009);
        wr(8'h00, 8'h08);
        repeat (50) @(posedge mclk);
        flag(1'b1);
        wr(8'h00, 8'h00);
        rd16(8'h04, v);
        chk({15'h0000, v <= 16'h0009}, 16'h0001);
        rd16(8'h04, w);
        chk(w, v);
        wr(8'h08, 8'h5A);
        rd16(8'h04, v);
        chk(v, 16'h0000);
    endtask : t_modulo
    task automatic t_tick;
        wr(8'h00, 8'h10);
        wr16(8'h0C, 16'h0004);
        rd16(8'h0C, v);
        chk(v, 16'h0009);
        repeat (12) begin
            tick <= 1'b1;
            repeat (3) @(posedge mclk);
            tick <= 1'b0;
            repeat (3) @(posedge mclk);
        end
        rd16(8'h0C, v);
        chk(v, 16'h0004);
    endtask : t_tick
    task automatic t_edge;
        wr(8'h00, 8'h00);
        wr16(8'h0C, 16'h0009);
        wr(8'h14, 8'h00);
        // the tick test left the count above the new modulo; restart from zero
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h08);
        wr16(8'h18, 16'h0000);
        duty(16'd0);
        wr(8'h1C, 8'h05);
        duty(16'd0);
        wr(8'h18, 8'h00);
        duty(16'd50);
        wr16(8'h18, 16'h000A);
        duty(16'd100);
    endtask : t_edge
    task automatic t_flag;
        wr(8'h00, 8'h00);
        wr16(8'h0C, 16'h0100);
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h08);
        wr(8'h0C, 8'h01);
        repeat (600) @(posedge mclk);
        flag(1'b0);
        wr(8'h10, 8'h00);
        repeat (600) @(posedge mclk);
        flag(1'b1);
        wr(8'h0C, 8'h00);
        wr(8'h00, 8'h00);
        wr(8'h10, 8'h09);
        rd16(8'h0C, v);
        chk(v, 16'h0100);
    endtask : t_flag
    // modulo 4 stays inside the range that center mode accepts
    task automatic t_center;
        // drops the lone modulo byte that the flag test left pending
        wr(8'h00, 8'h00);
        wr16(8'h0C, 16'h0004);
        wr(8'h04, 8'h00);
        wr16(8'h18, 16'h8002);
        wr(8'h00, 8'h28);
        duty(16'd0);
        wr16(8'h18, 16'h0005);
        duty(16'd100);
        wr(8'h14, 8'h04);
        duty(16'd0);
    endtask : t_center
    task automatic t_debug;
        dbg <= 1'b1;
        repeat (5) @(posedge mclk);
        rd16(8'h04, v);
        repeat (20) @(posedge mclk);
        rd16(8'h04, w);
        chk(w, v);
        wr(8'h00, 8'h28);
        wr(8'h04, 8'h33);
        rd16(8'h04, v);
        chk(v, 16'h0000);
        dbg <= 1'b0;
    endtask : t_debug
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_modulo;
        t_tick;
        t_edge;
        t_flag;
        t_center;
        t_debug;
        wrap_up;
    end
    // the sequence needs about 2500 cycles; 12500 cycles means a hang
    initial begin
        #100000;
        bad_count++;
        wrap_up;
    end
endmodule : tb_timer_pwm_counter
